// file: hdl/cc_attach_defs.vh
// Behaviour
// - Register mode: interrupt pin low while pending
// - Pin mode: audio pin low on audio accessory, host phase only (host or dual role)
// - Pin mode: current pins 00 high, 10 medium
// - Host role: identification pin low on sink
// - Chip disable high: hibernate, registers lost
// - Role from role pin, register write overrides
// - Pin mode: role follows role pin; a register write holds for one cycle at most
// - Host advertises default, medium, high; default first
// - Watch both lines, report sink or cable
// - Cable-attached bit cleared without connection
// - Attach, detach, current change raise interrupt
// - Device role: classify host current into register
// - Pin mode: current shown on current pins
// - Report which line carries the connection
// - Report line terminations and accessory modes
// - Role field: 00 device, 01 host, 10 dual
// - Current select: 00 default, 01 medium, 10 high
// - Mask bit suppresses attach/detach interrupts
// - Register mode: role pin sampled once only
`ifndef CC_ATTACH_DEFS_VH
`define CC_ATTACH_DEFS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define IDX_VERSION   6'h01
`define IDX_CONTROL   6'h02
`define IDX_INTSTAT   6'h03
`define IDX_CCSTAT    6'h04
`define IDX_TERMSTAT  6'h05

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define CTL_MASK_BIT  0
`define CTL_ROLE_LSB  1
`define CTL_RPSEL_LSB 3
`define RPSEL_RESET   2'h0
`define MASK_RESET    1'h0

// ************************************************************
// Interrupt status fields
// ************************************************************
`define INT_ATTACH_BIT 0
`define INT_DETACH_BIT 1
`define INT_CURCHG_BIT 2

// ************************************************************
// Encodings
// ************************************************************
`define ROLE_DEVICE   2'h0
`define ROLE_HOST     2'h1
`define ROLE_DUAL     2'h2
`define ROLE_RSVD     2'h3
`define CUR_DEFAULT   2'h0
`define CUR_MEDIUM    2'h1
`define CUR_HIGH      2'h2
`define CUR_RSVD      2'h3
`define TERM_OPEN     3'h0
`define TERM_RA       3'h1
`define TERM_RD       3'h2
`define TERM_RPDEF    3'h3
`define TERM_RPMED    3'h4
`define TERM_RPHIGH   3'h5
`define LEVEL_LOW     2'h0
`define LEVEL_MID     2'h1
`define LEVEL_HIGH    2'h2
`define PARTNER_NONE  2'h0
`define PARTNER_SINK  2'h1
`define PARTNER_SRC   2'h2
`define PARTNER_ACC   2'h3

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 20
`define DRP_HALF_NS   35000000
`define STRAP_SETTLE  2'h3

`endif

// file: hdl/cc_attach_detect_logic.v
`timescale 1ns/1ps
`include "cc_attach_defs.vh"
module cc_attach_detect_logic #(
  parameter       VERSION_CODE    = 5'h0A,  // Arbitrary value
  parameter       VENDOR_CODE     = 3'h5,   // Arbitrary value
  parameter       CNT_W           = 21,
  parameter       DRP_HALF_CYCLES = `DRP_HALF_NS / `CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  cc1Term,
  input  wire [2:0]  cc2Term,
  input  wire [1:0]  rolePinLevel,
  input  wire [1:0]  addrStrapLevel,
  input  wire        chip_disable_in,
  output reg         rpPresent,
  output reg         rdPresent,
  output reg  [1:0]  rpSelect,
  output reg         ccOrientation,
  output reg         connectDetect,
  output wire        interrupt_out_n,
  output reg         interruptOe_n,
  output wire        audio_detect_out_n,
  output reg         audioDetectOe_n,
  output wire        current_level_out_bit0,
  output reg         currentBit0Oe_n,
  output wire        current_level_out_bit1,
  output reg         currentBit1Oe_n,
  output wire        host_attach_indicator_n,
  output reg         hostAttachOe_n
);

  // ************************************************************
  // Local constants
  // ************************************************************
  localparam [7:0]       ADDR_VERSION  = {`IDX_VERSION, 2'b00};
  localparam [7:0]       ADDR_CONTROL  = {`IDX_CONTROL, 2'b00};
  localparam [7:0]       ADDR_INTSTAT  = {`IDX_INTSTAT, 2'b00};
  localparam [7:0]       ADDR_CCSTAT   = {`IDX_CCSTAT, 2'b00};
  localparam [7:0]       ADDR_TERMSTAT = {`IDX_TERMSTAT, 2'b00};
  localparam [CNT_W-1:0] DRP_LAST      = DRP_HALF_CYCLES[CNT_W-1:0] - 1'b1;

  // ************************************************************
  // Synchronised pin levels
  // ************************************************************
  wire [10:0] syncOut;
  wire [2:0]  term1     = syncOut[2:0];
  wire [2:0]  term2     = syncOut[5:3];
  wire [1:0]  rolePin   = syncOut[7:6];
  wire [1:0]  addrStrap = syncOut[9:8];
  wire        hibernate = syncOut[10];

  reg         odLow;

  sync_bits #(
    .WIDTH (11)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({chip_disable_in, addrStrapLevel, rolePinLevel, cc2Term, cc1Term}),
    .dout   (syncOut)
  );

  assign interrupt_out_n         = odLow;
  assign audio_detect_out_n      = odLow;
  assign current_level_out_bit0  = odLow;
  assign current_level_out_bit1  = odLow;
  assign host_attach_indicator_n = odLow;

  // ************************************************************
  // APB access decode
  // ************************************************************
  wire accessEdge = psel && penable && pready;
  wire writeEdge  = accessEdge && pwrite;
  wire readEdge   = accessEdge && !pwrite;

  // ************************************************************
  // Strap capture and role selection
  // ************************************************************
  reg  [1:0] strapCnt;
  reg        strapDone;
  reg        regMode;
  reg  [1:0] role;
  reg  [1:0] rpSel;
  reg        intMask;
  reg  [1:0] pinRole;

  always @* begin
    case (rolePin)
      `LEVEL_LOW:  pinRole = `ROLE_DEVICE;
      `LEVEL_HIGH: pinRole = `ROLE_HOST;
      default:     pinRole = `ROLE_DUAL;
    endcase
  end

  wire [1:0] wrRole  = pwdata[`CTL_ROLE_LSB+1:`CTL_ROLE_LSB];
  wire [1:0] wrRpSel = pwdata[`CTL_RPSEL_LSB+1:`CTL_RPSEL_LSB];
  wire       ctlWr   = writeEdge && (paddr == ADDR_CONTROL);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapCnt  <= 2'h0;
      strapDone <= 1'b0;
      regMode   <= 1'b0;
      role      <= `ROLE_DEVICE;
      rpSel     <= `RPSEL_RESET;
      intMask   <= `MASK_RESET;
    end else if (hibernate) begin
      strapCnt  <= 2'h0;
      strapDone <= 1'b0;
      regMode   <= 1'b0;
      role      <= `ROLE_DEVICE;
      rpSel     <= `RPSEL_RESET;
      intMask   <= `MASK_RESET;
    end else begin
      if (!strapDone) begin
        if (strapCnt == `STRAP_SETTLE) begin
          strapDone <= 1'b1;
          regMode   <= (addrStrap != `LEVEL_MID);
          role      <= pinRole;
        end else begin
          strapCnt <= strapCnt + 2'h1;
        end
      end else if (!regMode && (pinRole != role)) begin
        role <= pinRole;
      end else if (ctlWr && (wrRole != `ROLE_RSVD)) begin
        role <= wrRole;
      end
      if (ctlWr) begin
        intMask <= pwdata[`CTL_MASK_BIT];
        if (wrRpSel != `CUR_RSVD) begin
          rpSel <= wrRpSel;
        end
      end
    end
  end

  // ************************************************************
  // Presentation: host, device or toggling dual role
  // ************************************************************
  reg             attached;
  reg             hostPhase;
  reg [CNT_W-1:0] drpCnt;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hostPhase <= 1'b0;
      drpCnt    <= {CNT_W{1'b0}};
    end else if (hibernate || !strapDone) begin
      hostPhase <= 1'b0;
      drpCnt    <= {CNT_W{1'b0}};
    end else begin
      case (role)
        `ROLE_HOST: begin
          hostPhase <= 1'b1;
          drpCnt    <= {CNT_W{1'b0}};
        end
        `ROLE_DUAL: begin
          if (attached) begin
            drpCnt <= {CNT_W{1'b0}};
          end else if (drpCnt == DRP_LAST) begin
            drpCnt    <= {CNT_W{1'b0}};
            hostPhase <= !hostPhase;
          end else begin
            drpCnt <= drpCnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          hostPhase <= 1'b0;
          drpCnt    <= {CNT_W{1'b0}};
        end
      endcase
    end
  end

  // ************************************************************
  // Line classification
  // ************************************************************
  wire ra1 = (term1 == `TERM_RA);
  wire ra2 = (term2 == `TERM_RA);
  wire rd1 = (term1 == `TERM_RD);
  wire rd2 = (term2 == `TERM_RD);
  wire rp1 = (term1 >= `TERM_RPDEF) && (term1 <= `TERM_RPHIGH);
  wire rp2 = (term2 >= `TERM_RPDEF) && (term2 <= `TERM_RPHIGH);

  reg       attachNow;
  reg       orientNow;
  reg       audioNow;
  reg       debugNow;
  reg       cableNow;
  reg [1:0] partnerNow;
  reg [1:0] currentNow;
  reg [2:0] srcTerm;

  always @* begin
    attachNow  = 1'b0;
    orientNow  = 1'b0;
    audioNow   = 1'b0;
    debugNow   = 1'b0;
    cableNow   = 1'b0;
    partnerNow = `PARTNER_NONE;
    currentNow = `CUR_DEFAULT;
    srcTerm    = rp1 ? term1 : term2;
    if (strapDone && hostPhase) begin
      audioNow  = ra1 && ra2;
      debugNow  = rd1 && rd2;
      cableNow  = (ra1 && rd2) || (rd1 && ra2);
      attachNow = rd1 || rd2 || audioNow;
      orientNow = rd2 && !rd1;
      if (audioNow || debugNow) begin
        partnerNow = `PARTNER_ACC;
      end else if (attachNow) begin
        partnerNow = `PARTNER_SINK;
      end
    end else if (strapDone) begin
      debugNow  = rp1 && rp2;
      attachNow = rp1 || rp2;
      orientNow = rp2 && !rp1;
      partnerNow = debugNow ? `PARTNER_ACC : (attachNow ? `PARTNER_SRC : `PARTNER_NONE);
      case (srcTerm)
        `TERM_RPMED:  currentNow = `CUR_MEDIUM;
        `TERM_RPHIGH: currentNow = `CUR_HIGH;
        default:      currentNow = `CUR_DEFAULT;
      endcase
    end
  end

  // ************************************************************
  // Attach state and events
  // ************************************************************
  reg       orientation;
  reg       audioAcc;
  reg       debugAcc;
  reg       cablePowered;
  reg [1:0] partner;
  reg [1:0] currentDet;
  reg [2:0] termSeen1;
  reg [2:0] termSeen2;
  reg [2:0] intStat;

  wire evAttach = attachNow && !attached;
  wire evDetach = !attachNow && attached;
  wire evCurChg = attachNow && attached && !hostPhase && (currentNow != currentDet);
  wire intRead  = readEdge && (paddr == ADDR_INTSTAT);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      attached     <= 1'b0;
      orientation  <= 1'b0;
      audioAcc     <= 1'b0;
      debugAcc     <= 1'b0;
      cablePowered <= 1'b0;
      partner      <= `PARTNER_NONE;
      currentDet   <= `CUR_DEFAULT;
      termSeen1    <= `TERM_OPEN;
      termSeen2    <= `TERM_OPEN;
      intStat      <= 3'h0;
    end else if (hibernate) begin
      attached     <= 1'b0;
      orientation  <= 1'b0;
      audioAcc     <= 1'b0;
      debugAcc     <= 1'b0;
      cablePowered <= 1'b0;
      partner      <= `PARTNER_NONE;
      currentDet   <= `CUR_DEFAULT;
      termSeen1    <= `TERM_OPEN;
      termSeen2    <= `TERM_OPEN;
      intStat      <= 3'h0;
    end else begin
      attached     <= attachNow;
      orientation  <= orientNow;
      audioAcc     <= audioNow;
      debugAcc     <= debugNow;
      cablePowered <= attachNow && cableNow;
      partner      <= partnerNow;
      currentDet   <= currentNow;
      termSeen1    <= term1;
      termSeen2    <= term2;
      // Read clears only the bits it reported; set wins
      intStat <= (intRead ? (intStat & ~prdata[2:0]) : intStat)
                 | {evCurChg, evDetach, evAttach};
    end
  end

  wire pending = intStat[`INT_CURCHG_BIT] || (!intMask && (intStat[`INT_ATTACH_BIT]
                 || intStat[`INT_DETACH_BIT]));

  // ************************************************************
  // Pin and front-end outputs
  // ************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      odLow           <= 1'b0;
      rpPresent       <= 1'b0;
      rdPresent       <= 1'b1;
      rpSelect        <= `RPSEL_RESET;
      ccOrientation   <= 1'b0;
      connectDetect   <= 1'b0;
      interruptOe_n   <= 1'b1;
      audioDetectOe_n <= 1'b1;
      currentBit0Oe_n <= 1'b1;
      currentBit1Oe_n <= 1'b1;
      hostAttachOe_n  <= 1'b1;
    end else begin
      odLow           <= 1'b0;
      rpPresent       <= hostPhase && !hibernate;
      rdPresent       <= !hostPhase || hibernate;
      rpSelect        <= rpSel;
      ccOrientation   <= orientation;
      connectDetect   <= attached;
      interruptOe_n   <= !(regMode && pending);
      audioDetectOe_n <= !(!regMode && strapDone && audioAcc);
      hostAttachOe_n  <= !(hostPhase && !hibernate && attached
                           && (partner == `PARTNER_SINK));
      if (!regMode && strapDone && attached && (partner == `PARTNER_SRC)) begin
        // Bit1 driven only for high; both released for default
        currentBit0Oe_n <= (currentDet == `CUR_DEFAULT);
        currentBit1Oe_n <= (currentDet != `CUR_HIGH);
      end else begin
        currentBit0Oe_n <= 1'b1;
        currentBit1Oe_n <= 1'b1;
      end
    end
  end

  // ************************************************************
  // APB slave: one wait-free access cycle, registered answer
  // ************************************************************
  reg [31:0] next_prdata;
  reg        next_pslverr;

  always @* begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_VERSION:  next_prdata[7:0] = {VERSION_CODE, VENDOR_CODE};
      ADDR_CONTROL:  next_prdata[7:0] = {3'h0, rpSel, role, intMask};
      ADDR_INTSTAT:  next_prdata[7:0] = {5'h00, intStat};
      ADDR_CCSTAT:   next_prdata[7:0] = {hostPhase, cablePowered, currentDet,
                                         partner, orientation, attached};
      ADDR_TERMSTAT: next_prdata[7:0] = {debugAcc, audioAcc, termSeen2, termSeen1};
      default:       next_pslverr = 1'b1;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && next_pslverr;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule // cc_attach_detect_logic

// file: hdl/sync_bits.v
`timescale 1ns/1ps
// ************************************************************
// Two-flop synchroniser for a group of pin levels
// ************************************************************
module sync_bits #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // sync_bits

// file: test/cc_attach_monitor.sv
`timescale 1ns/1ps
module cc_attach_monitor (
  input wire       clk,
  input wire       arst_n,
  input wire [2:0] cc1Term,
  input wire [2:0] cc2Term,
  input wire [1:0] addrStrapLevel,
  input wire       chip_disable_in,
  input wire       rpPresent,
  input wire [1:0] rpSelect,
  input wire       connectDetect,
  input wire       interruptOe_n,
  input wire       audioDetectOe_n,
  input wire       currentBit0Oe_n,
  input wire       currentBit1Oe_n,
  input wire       hostAttachOe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_int_reg_only: assert property (!interruptOe_n |-> addrStrapLevel != 2'h1)
    else $error("interrupt pin driven in pin-only mode");
  a_audio_pin_only: assert property (!audioDetectOe_n |-> addrStrapLevel == 2'h1)
    else $error("audio pin driven in register mode");
  a_cur_code_legal: assert property (!currentBit1Oe_n |-> !currentBit0Oe_n)
    else $error("current pins show an undefined pattern");
  a_cur_pin_only: assert property ((!currentBit0Oe_n || !currentBit1Oe_n)
    |-> addrStrapLevel == 2'h1) else $error("current pins driven in register mode");
  a_host_ind_role: assert property (!hostAttachOe_n |-> rpPresent)
    else $error("host indicator low outside host phase");
  a_host_ind_idle: assert property ((!connectDetect) [*3] |-> hostAttachOe_n)
    else $error("host indicator low without attach");
  a_disable_quiet: assert property (chip_disable_in [*5] |->
    (interruptOe_n && audioDetectOe_n && hostAttachOe_n && !connectDetect))
    else $error("state kept while chip disabled");
  a_rpsel_reset: assert property ($rose(arst_n) |-> rpSelect == 2'h0)
    else $error("advertised current not default after reset");
  a_rpsel_legal: assert property (rpSelect != 2'h3)
    else $error("reserved current select in use");
  a_open_detach: assert property ((cc1Term == 3'h0 && cc2Term == 3'h0) [*5]
    |-> !connectDetect) else $error("attached with both lines open");
endmodule // cc_attach_monitor
bind cc_attach_detect_logic cc_attach_monitor i_cc_attach_monitor (
  .clk(clk), .arst_n(arst_n), .cc1Term(cc1Term), .cc2Term(cc2Term),
  .addrStrapLevel(addrStrapLevel), .chip_disable_in(chip_disable_in),
  .rpPresent(rpPresent), .rpSelect(rpSelect), .connectDetect(connectDetect),
  .interruptOe_n(interruptOe_n), .audioDetectOe_n(audioDetectOe_n),
  .currentBit0Oe_n(currentBit0Oe_n), .currentBit1Oe_n(currentBit1Oe_n),
  .hostAttachOe_n(hostAttachOe_n));

// file: test/cc_partner_model.sv
`timescale 1ns/1ps
// ****
// Port partner seen on CC1 and CC2
// ****
module cc_partner_model (
  input  wire       rpPresent,
  input  wire [2:0] kind,
  input  wire       flip,
  input  wire [1:0] level,
  output wire [2:0] cc1Term,
  output wire [2:0] cc2Term
);
  reg [2:0] near;
  reg [2:0] far;
  // Kinds: 0 none, 1 sink, 2 source, 3 audio, 4 powered cable, 5 debug source
  // A sink's Rd only shows while our side pulls up
  always @* begin
    far = 3'h0;
    case (kind)
      3'h1: near = rpPresent ? 3'h2 : 3'h0;
      3'h2: near = 3'h3 + {1'b0, level};
      3'h3: begin
        near = 3'h1;
        far  = 3'h1;
      end
      3'h4: begin
        near = rpPresent ? 3'h2 : 3'h0;
        far  = 3'h1;
      end
      3'h5: begin
        near = 3'h3;
        far  = 3'h3;
      end
      default: near = 3'h0;
    endcase
  end
  assign cc1Term = flip ? far : near;
  assign cc2Term = flip ? near : far;
endmodule // cc_partner_model

// file: test/tb_top.sv
`timescale 1ns/1ps
`include "cc_attach_defs.vh"
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
  fail_count = fail_count + 1; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg         clk = 1'b0;
  reg         arst_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [1:0]  rolePinLevel = 2'h2;
  reg  [1:0]  addrStrapLevel = 2'h0;
  reg         chip_disable_in = 1'b0;
  reg  [2:0]  kind = 3'h0;
  reg         flip = 1'b0;
  reg  [1:0]  level = 2'h0;
  reg  [31:0] rd;
  reg         err;
  reg  [31:0] rows [0:8];
  reg  [1:0]  role;
  reg  [2:0]  k;
  reg         f;
  reg  [1:0]  l;
  reg  [7:0]  m;
  reg  [7:0]  ec;
  reg  [7:0]  et;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [2:0]  cc1Term;
  wire [2:0]  cc2Term;
  wire        rpPresent;
  wire [1:0]  rpSelect;
  wire        interruptOe_n;
  wire        audioDetectOe_n;
  wire        currentBit0Oe_n;
  wire        currentBit1Oe_n;
  wire        hostAttachOe_n;
  wire        rdPresent;
  wire        ccOrientation;
  wire        connectDetect;
  wire [4:0]  odData;
  integer     fail_count = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     i;
  localparam [7:0] CTRL = {`IDX_CONTROL, 2'b00};
  localparam [7:0] INTS = {`IDX_INTSTAT, 2'b00};
  localparam [7:0] CCST = {`IDX_CCSTAT, 2'b00};
  localparam [7:0] TERM = {`IDX_TERMSTAT, 2'b00};
  // Version 5'h03 and vendor 3'h2 are arbitrary
  cc_attach_detect_logic #(.VERSION_CODE(5'h03), .VENDOR_CODE(3'h2), .DRP_HALF_CYCLES(20))
    i_cc_attach_detect_logic (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc1Term(cc1Term), .cc2Term(cc2Term), .rolePinLevel(rolePinLevel),
    .addrStrapLevel(addrStrapLevel), .chip_disable_in(chip_disable_in),
    .rpPresent(rpPresent), .rdPresent(rdPresent), .rpSelect(rpSelect),
    .ccOrientation(ccOrientation), .connectDetect(connectDetect),
    .interrupt_out_n(odData[0]), .interruptOe_n(interruptOe_n),
    .audio_detect_out_n(odData[1]), .audioDetectOe_n(audioDetectOe_n),
    .current_level_out_bit0(odData[2]), .currentBit0Oe_n(currentBit0Oe_n),
    .current_level_out_bit1(odData[3]), .currentBit1Oe_n(currentBit1Oe_n),
    .host_attach_indicator_n(odData[4]), .hostAttachOe_n(hostAttachOe_n));
  cc_partner_model i_cc_partner_model (.rpPresent(rpPresent), .kind(kind), .flip(flip),
    .level(level), .cc1Term(cc1Term), .cc2Term(cc2Term));
  // ****
  // Clock, timeout and bus tasks
  // ****
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input reg wr, input reg [7:0] a, input reg [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input string n, input reg [7:0] a, input reg [7:0] msk, input reg [7:0] e);
    begin
      apb(1'b0, a, 8'h00);
      `CHK(n, {24'h0, e}, rd & {24'h0, msk})
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    // {role, kind, flip, level, status mask, status, terminations}
    rows[0] = 32'h48FF8502;
    rows[1] = 32'h4CFF8710;
    rows[2] = 32'h12FF2905;
    rows[3] = 32'h15FF1B20;
    rows[4] = 32'h10FF0903;
    rows[5] = 32'h580C0C49;
    rows[6] = 32'h644C4411;
    rows[7] = 32'h280C0C9B;
    rows[8] = 32'h88FF8502;
    tick(3);
    arst_n <= 1'b1;
    tick(10);
    rdc("control reset", CTRL, 8'hFF, 8'h02);
    for (i = 0; i < 9; i = i + 1) begin
      {role, k, f, l, m, ec, et} = rows[i];
      apb(1'b1, CTRL, {5'h00, role, 1'b0});
      kind <= k;
      flip <= f;
      level <= l;
      tick(60);
      rdc("ccstat", CCST, m, ec);
      `CHK("connect pin", m[0], connectDetect & m[0])
      `CHK("orientation pin", ec[1], ccOrientation & m[1])
      rdc("termstat", TERM, 8'hFF, et);
      rdc("attach event", INTS, {7'h0, m[0]}, {7'h0, m[0]});
      tick(3);
      `CHK("int released", 1'b1, interruptOe_n)
      kind <= 3'h0;
      tick(10);
      rdc("detached", CCST, {7'h0, m[0]}, 8'h00);
      `CHK("connect released", 1'b0, connectDetect)
      rdc("detach event", INTS, {6'h0, m[0], 1'b0}, {6'h0, m[0], 1'b0});
    end
    apb(1'b1, CTRL, 8'h12);
    tick(2);
    `CHK("rpSelect", 2'h2, rpSelect)
    apb(1'b1, CTRL, 8'h1F);
    rdc("reserved codes", CTRL, 8'hFF, 8'h13);
    kind <= 3'h1;
    tick(20);
    `CHK("masked int", 1'b1, interruptOe_n)
    rdc("masked event", INTS, 8'h01, 8'h01);
    kind <= 3'h0;
    apb(1'b1, CTRL, 8'h10);
    kind <= 3'h2;
    tick(20);
    apb(1'b0, INTS, 8'h00);
    level <= 2'h2;
    tick(10);
    `CHK("current int", 1'b0, interruptOe_n)
    rdc("current event", INTS, 8'h04, 8'h04);
    rdc("current level", CCST, 8'h30, 8'h20);
    kind <= 3'h0;
    apb(1'b0, 8'h40, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    rdc("version", {`IDX_VERSION, 2'b00}, 8'hFF, 8'h1A);
    apb(1'b1, CTRL, 8'h13);
    rolePinLevel <= 2'h0;
    tick(10);
    rdc("pin ignored", CTRL, 8'hFF, 8'h13);
    chip_disable_in <= 1'b1;
    tick(8);
    chip_disable_in <= 1'b0;
    tick(10);
    rdc("after disable", CTRL, 8'hFF, 8'h00);
    arst_n <= 1'b0;
    addrStrapLevel <= 2'h1;
    kind <= 3'h2;
    level <= 2'h1;
    tick(3);
    arst_n <= 1'b1;
    tick(20);
    `CHK("medium bit0", 1'b0, currentBit0Oe_n)
    `CHK("medium bit1", 1'b1, currentBit1Oe_n)
    level <= 2'h2;
    tick(10);
    `CHK("high bits", 2'h0, {currentBit1Oe_n, currentBit0Oe_n})
    level <= 2'h0;
    tick(10);
    `CHK("default bits", 2'h3, {currentBit1Oe_n, currentBit0Oe_n})
    `CHK("no int pin", 1'b1, interruptOe_n)
    kind <= 3'h0;
    rolePinLevel <= 2'h2;
    tick(20);
    `CHK("role follows pin", 1'b1, rpPresent)
    `CHK("rd released", 1'b0, rdPresent)
    kind <= 3'h3;
    tick(20);
    `CHK("audio pin", 1'b0, audioDetectOe_n)
    kind <= 3'h1;
    tick(20);
    `CHK("audio released", 1'b1, audioDetectOe_n)
    `CHK("host indicator", 1'b0, hostAttachOe_n)
    `CHK("open drain data", 5'h00, odData)
    rolePinLevel <= 2'h1;
    tick(10);
    rdc("pin dual", CTRL, 8'h06, 8'h04);
    report_and_stop;
  end
endmodule // tb_top
